//--- logic/hie_defs.vh
// constants for the host event enable and mask block
`ifndef HIE_DEFS_VH
`define HIE_DEFS_VH
`define HIE_CMD_RD_ENABLE     8'h25
`define HIE_CMD_WR_ENABLE     8'ha5
`define HIE_ENABLE_RESET      16'h0000
`define HIE_ENABLE_WMASK      16'h0077
`define HIE_BIT_CLK_READY     6
`define HIE_BIT_SUSPENDED     5
`define HIE_BIT_OPER_UPDATE   4
`define HIE_BIT_TRANSFER_DONE 2
`define HIE_BIT_ASYNC_LIST    1
`define HIE_BIT_SOF           0
`define HIE_CFG_PIN_GATE_BIT  0
`define HIE_CLK_READY_MAX_US  1000
`define HIE_CLK_MHZ           100
`endif

//--- logic/hie_event_latch.v
// sticky host event status flags with set-over-clear
`timescale 1ns/1ps
`default_nettype none
module hie_event_latch #(
   parameter WIDTH = 7
) (
   input  wire             i_clk,
   input  wire             i_reset,
   input  wire [WIDTH-1:0] i_set,
   input  wire [WIDTH-1:0] i_clear,
   output reg  [WIDTH-1:0] o_flags
);
   genvar g;
   // a set arriving with its clear wins so no event is lost
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_flag
         always @(posedge i_clk) begin
            if (i_reset) begin
               o_flags[g] <= 1'b0;
            end else if (i_set[g]) begin
               o_flags[g] <= 1'b1;
            end else if (i_clear[g]) begin
               o_flags[g] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- logic/hie_enable_mask.v
// host event enable register, status flags and interrupt pin gating
//
// Notes on behaviour
// - enable bits 6..0 mirror status flag positions
// - event needs own enable and global pin gate
// - reset clears all enables, pin stays quiet
// - writing one to enable unmasks that event
// - command 25h reads, a5h plus data writes
// - bit 6 gates clock ready event
// - bit 5 gates host suspended event
// - suspended host stops issuing start of frame
// - bit 4 gates operational register update event
// - bit 2 gates end of transfer event
// - bit 1 gates async transfer list event
// - async list timing follows per-frame clock budget
// - bit 0 gates start of frame event
// - internal or external transfer end sets flag
// - clock ready within 1 ms of wake-up
//
// Usage notes
// - a command cycle picks the direction and the data cycle after it
//   completes it; a lone data strobe is ignored
// - a new command abandons any exchange still waiting for data
// - read data appears one cycle after the read strobe and holds
//   until the next read; the valid flag is a one-cycle pulse
// - read data for an aborted read is not refreshed
// - written enables take effect one cycle after the write strobe
//   and the pin follows one cycle later
// - status flags are sticky; a clear racing a set loses, so an
//   event is never dropped between two polls
// - the pin is registered so it cannot glitch while flags settle
// - the clock-ready watchdog forces the flag at its limit and keeps
//   a late indication so software can tell a forced ready apart
// - suspend needs both the control write and idle downstream
//   ports; only a resume or a reset brings start of frame back
// - the async list tick fires once per frame at the budget cycle;
//   a budget at or past the frame length never fires
// - the frame timer is held at zero while start of frame is off
// - flag 3 has no source, so its enable bit never matters
// - reserved positions 15..7 and 3 are dropped on write
//
// Reset
// - synchronous, active high; every enable, flag and the pin clear
// - start of frame is enabled out of reset
//
// Parameters
// - CLK_READY_MAX_CYC: watchdog limit in clock cycles
// - FRAME_CYC: clock cycles in one frame
// - both are counted in cycles of i_clk
`timescale 1ns/1ps
`default_nettype none
`include "hie_defs.vh"
module hie_enable_mask #(
   parameter CLK_READY_MAX_CYC = `HIE_CLK_READY_MAX_US * `HIE_CLK_MHZ,
   parameter FRAME_CYC         = 100000
) (
   // clock and synchronous reset
   input  wire        i_clk,
   input  wire        i_reset,
   // shared parallel port command and data phases
   input  wire        i_cmd_valid,
   input  wire [7:0]  i_cmd_code,
   input  wire        i_data_wr,
   input  wire [15:0] i_data_in,
   input  wire        i_data_rd,
   output reg  [15:0] o_data_out,
   output reg         o_data_valid,
   // global pin gate from the hardware configuration register
   input  wire [15:0] i_host_hw_config,
   // clock wake-up: the wait starts on the pulse, ends on stable
   input  wire        i_clk_wakeup,
   input  wire        i_clk_stable,
   // suspend request from the control write, downstream idle level
   input  wire        i_suspend_req,
   input  wire        i_all_downstream_susp,
   // event pulses from the transfer engine
   input  wire        i_oper_update,
   input  wire        i_transfer_end_int,
   input  wire        i_transfer_end_ext,
   // cycle within the frame at which the async list tick fires
   input  wire [15:0] i_async_budget_cyc,
   // resume brings start of frame back
   input  wire        i_resume,
   // one clear strobe per status flag
   input  wire [6:0]  i_status_clear,
   // sticky flags, frame gate, watchdog late flag and the pin
   output wire [6:0]  o_host_event_status,
   output reg         o_sof_enable,
   output wire        o_clk_ready_late,
   output reg         o_host_irq_out
);
   // port sequencer states
   localparam ST_IDLE  = 2'd0;
   localparam ST_WDATA = 2'd1;
   localparam ST_RDATA = 2'd2;

   // port sequencer and enable register
   reg  [1:0]  port_q;
   reg  [1:0]  port_d;
   reg  [15:0] host_event_enable_mask_q;

   // clock ready watchdog
   reg         wait_clk_q;
   reg  [31:0] wake_cnt_q;
   reg         late_q;

   // suspend tracking and frame timer
   reg         susp_armed_q;
   reg  [31:0] frame_cnt_q;
   reg         async_fired_q;

   // event strobes and the gated view of the flags
   wire [6:0]  ev_set;
   wire        sof_tick;
   wire        async_tick;
   wire        global_irq_pin_gate;
   wire [6:0]  gated_ev;
   wire        wr_hit;
   wire        rd_hit;

   // command decode shared by both directions of the port
   function cmd_is;
      input       valid;
      input [7:0] code;
      input [7:0] want;
      begin
         cmd_is = valid && (code == want);
      end
   endfunction

   // data strobes only count inside the matching exchange
   assign wr_hit = (port_q == ST_WDATA) && i_data_wr;
   assign rd_hit = (port_q == ST_RDATA) && i_data_rd;

   // command phase picks direction, data phase completes it
   always @* begin
      port_d = port_q;
      case (port_q)
         ST_IDLE: begin
            if (cmd_is(i_cmd_valid, i_cmd_code, `HIE_CMD_WR_ENABLE)) begin
               port_d = ST_WDATA;
            end else if (cmd_is(i_cmd_valid, i_cmd_code,
                                `HIE_CMD_RD_ENABLE)) begin
               port_d = ST_RDATA;
            end
         end
         ST_WDATA: begin
            if (i_data_wr) begin
               port_d = ST_IDLE;
            end
         end
         ST_RDATA: begin
            if (i_data_rd) begin
               port_d = ST_IDLE;
            end
         end
         default: port_d = ST_IDLE;
      endcase
      // a fresh command mid-exchange drops back to idle without being decoded
      if (i_cmd_valid && port_q != ST_IDLE) begin
         port_d = ST_IDLE;
      end
   end

   // enable register; reserved positions are never stored
   always @(posedge i_clk) begin
      if (i_reset) begin
         port_q                   <= ST_IDLE;
         host_event_enable_mask_q <= `HIE_ENABLE_RESET;
         o_data_out               <= 16'h0000;
         o_data_valid             <= 1'b0;
      end else begin
         port_q       <= port_d;
         o_data_valid <= 1'b0;
         if (wr_hit) begin
            host_event_enable_mask_q <= i_data_in & `HIE_ENABLE_WMASK;
         end
         if (rd_hit) begin
            o_data_out   <= host_event_enable_mask_q;
            o_data_valid <= 1'b1;
         end
      end
   end

   // wake-up watchdog: clock ready flag must follow within 1 ms
   always @(posedge i_clk) begin
      if (i_reset) begin
         wait_clk_q <= 1'b0;
         wake_cnt_q <= 32'h0000_0000;
         late_q     <= 1'b0;
      end else if (i_clk_wakeup) begin
         wait_clk_q <= 1'b1;
         wake_cnt_q <= 32'h0000_0000;
         late_q     <= 1'b0;
      end else if (wait_clk_q) begin
         if (i_clk_stable) begin
            wait_clk_q <= 1'b0;
         end else if (wake_cnt_q == CLK_READY_MAX_CYC - 1) begin
            wait_clk_q <= 1'b0;
            late_q     <= 1'b1; // forced ready so software never hangs
         end else begin
            wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
         end
      end
   end
   assign o_clk_ready_late = late_q;

   // suspend: control write arms it, downstream idle completes it
   always @(posedge i_clk) begin
      if (i_reset) begin
         susp_armed_q <= 1'b0;
         o_sof_enable <= 1'b1;
      end else if (i_resume) begin
         // resume wins over a suspend request in the same cycle
         susp_armed_q <= 1'b0;
         o_sof_enable <= 1'b1;
      end else begin
         if (i_suspend_req) begin
            susp_armed_q <= 1'b1;
         end
         if (susp_armed_q && i_all_downstream_susp) begin
            o_sof_enable <= 1'b0;
         end
      end
   end

   // frame timer; async list tick lands after the activity budget
   always @(posedge i_clk) begin
      if (i_reset) begin
         frame_cnt_q   <= 32'h0000_0000;
         async_fired_q <= 1'b0;
      end else if (sof_tick || !o_sof_enable) begin
         // held at zero while suspended so resume starts a clean frame
         frame_cnt_q   <= 32'h0000_0000;
         async_fired_q <= 1'b0;
      end else begin
         frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
         if (async_tick) begin
            async_fired_q <= 1'b1;
         end
      end
   end
   assign sof_tick   = o_sof_enable && (frame_cnt_q == FRAME_CYC - 1);
   assign async_tick = o_sof_enable && !async_fired_q &&
                       (frame_cnt_q == {16'h0000, i_async_budget_cyc});

   // event set vector placed at the status flag positions
   // clock ready on a stable clock or at the watchdog limit
   assign ev_set[`HIE_BIT_CLK_READY]  = wait_clk_q &&
      (i_clk_stable || wake_cnt_q == CLK_READY_MAX_CYC - 1);
   // suspended when an armed request meets idle downstream ports while start of frame is on
   assign ev_set[`HIE_BIT_SUSPENDED]  =
      susp_armed_q && i_all_downstream_susp && o_sof_enable;
   // operational register update
   assign ev_set[`HIE_BIT_OPER_UPDATE] = i_oper_update;
   assign ev_set[3]                    = 1'b0; // reserved position
   assign ev_set[`HIE_BIT_TRANSFER_DONE] = i_transfer_end_int |
                                           i_transfer_end_ext;
   // async list tick
   assign ev_set[`HIE_BIT_ASYNC_LIST] = async_tick;
   // start of frame tick
   assign ev_set[`HIE_BIT_SOF]        = sof_tick;

   // sticky status flags; a set wins over a clear in the same cycle
   hie_event_latch #(
      .WIDTH (7)
   ) u_latch (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_set   (ev_set),
      .i_clear (i_status_clear),
      .o_flags (o_host_event_status)
   );

   // global pin gate
   assign global_irq_pin_gate = i_host_hw_config[`HIE_CFG_PIN_GATE_BIT];

   // per-flag gating; one and gate for each status position
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_gate
         assign gated_ev[g] = o_host_event_status[g] &
                              host_event_enable_mask_q[g];
      end
   endgenerate

   // pin is registered; bit 3 never sets so its enable is moot
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_host_irq_out <= 1'b0;
      end else begin
         o_host_irq_out <= global_irq_pin_gate && (|gated_ev);
      end
   end
endmodule
`default_nettype wire

//--- verification/hie_mask_chk_props.sv
// assertions on the host event enable and mask ports
`timescale 1ns/1ps
`default_nettype none
module hie_mask_chk #(
   parameter int CLK_READY_MAX_CYC = 50
) (
   input wire        i_clk,
   input wire        i_reset,
   input wire        i_cmd_valid,
   input wire [7:0]  i_cmd_code,
   input wire        i_data_rd,
   input wire [15:0] i_host_hw_config,
   input wire        i_clk_wakeup,
   input wire        i_transfer_end_int,
   input wire        i_transfer_end_ext,
   input wire [15:0] o_data_out,
   input wire        o_data_valid,
   input wire [6:0]  o_host_event_status,
   input wire        o_sof_enable,
   input wire        o_host_irq_out
);
   // one edge for the flag register behind the timeout, plus one spare
   localparam int RDY_LIM = CLK_READY_MAX_CYC + 2;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   rst_quiet_a: assert property (
      $fell(i_reset) |-> !o_host_irq_out && o_sof_enable
      && o_host_event_status == 7'h00) else $error("busy after reset");
   pin_gate_a: assert property (
      !i_host_hw_config[0] |=> !o_host_irq_out) else $error("gate ignored");
   no_flag_a: assert property (
      o_host_event_status == 7'h00 |=> !o_host_irq_out)
      else $error("irq without flag");
   rd_answer_a: assert property (
      i_cmd_valid && i_cmd_code == 8'h25 ##1 i_data_rd && !i_cmd_valid
      |=> o_data_valid ##1 !o_data_valid) else $error("read answer");
   rsvd_zero_a: assert property (
      o_data_valid |-> o_data_out[15:7] == 9'h000 && !o_data_out[3])
      else $error("reserved bit set");
   eot_set_a: assert property (
      i_transfer_end_int || i_transfer_end_ext |=> o_host_event_status[2])
      else $error("transfer end lost");
   rdy_bound_a: assert property (
      i_clk_wakeup |-> ##[1:RDY_LIM] o_host_event_status[6])
      else $error("clock ready late");
   susp_flag_a: assert property (
      $fell(o_sof_enable) |-> ##[0:1] o_host_event_status[5])
      else $error("suspend flag missing");
endmodule
bind hie_enable_mask hie_mask_chk #(
   .CLK_READY_MAX_CYC(CLK_READY_MAX_CYC)) chk_u (.*);
`default_nettype wire

//--- verification/hie_cpu_model.sv
// processor side of the shared parallel port
`timescale 1ns/1ps
`default_nettype none
module hie_cpu_model (
   input  wire              i_clk,
   input  wire       [15:0] i_rdata,
   input  wire              i_rvalid,
   output var logic         o_cmd,
   output var logic  [7:0]  o_code,
   output var logic         o_wr,
   output var logic  [15:0] o_wdata,
   output var logic         o_rd,
   output var logic         o_susp
);
   initial {o_cmd, o_code, o_wr, o_wdata, o_rd, o_susp} = '0;
   // released lines flip so a stale value never passes for data
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge i_clk);
      o_cmd = 1;
      o_code = c;
      @(negedge i_clk);
      o_cmd = 0;
      o_code = ~c;
      o_wr = 1;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 0;
      o_wdata = ~d;
   endtask
   // answer is sampled once, a missing valid yields unknown
   task automatic rd(output logic [15:0] d);
      @(negedge i_clk);
      o_cmd = 1;
      o_code = 8'h25;
      @(negedge i_clk);
      o_cmd = 0;
      o_code = 8'hda;
      o_rd = 1;
      @(negedge i_clk);
      o_rd = 0;
      d = i_rvalid ? i_rdata : 16'hxxxx;
   endtask
   // suspend is a control register write pulse
   task automatic suspend;
      @(negedge i_clk);
      o_susp = 1;
      @(negedge i_clk);
      o_susp = 0;
   endtask
endmodule
`default_nettype wire

//--- verification/hie_enable_mask_tb.sv
// bench for the host event enable and mask block
`timescale 1ns/1ps
`default_nettype none
module hie_enable_mask_tb;
   logic i_clk, i_reset, i_clk_wakeup, i_clk_stable, i_suspend_req;
   logic i_all_downstream_susp, i_oper_update, i_transfer_end_int;
   logic i_transfer_end_ext, i_resume, i_data_rd, i_data_wr, i_cmd_valid;
   logic o_data_valid, o_sof_enable, o_clk_ready_late, o_host_irq_out;
   logic [7:0]  i_cmd_code;
   logic [15:0] i_data_in, i_host_hw_config, i_async_budget_cyc;
   logic [15:0] o_data_out, rv;
   logic [6:0]  i_status_clear, o_host_event_status;
   integer      bad_count = 0;
   integer      num_checks = 0;
   int          bits[6] = '{6, 5, 4, 2, 1, 0};
   hie_enable_mask #(.CLK_READY_MAX_CYC(50), .FRAME_CYC(200)) dut_u (.*);
   hie_cpu_model cpu_u (.i_clk, .i_rdata(o_data_out),
      .i_rvalid(o_data_valid), .o_cmd(i_cmd_valid), .o_code(i_cmd_code),
      .o_wr(i_data_wr), .o_wdata(i_data_in), .o_rd(i_data_rd),
      .o_susp(i_suspend_req));
   initial begin
      i_clk = 0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // reset value, write mask and a stray command code
   task t_regs;
      cpu_u.rd(rv);
      chk(rv, 16'h0000);
      chk(o_host_irq_out, 1'b0);
      cpu_u.wr(8'ha5, 16'hffff);
      cpu_u.rd(rv);
      chk(rv, 16'h0077);
      cpu_u.wr(8'ha8, 16'h0000);
      cpu_u.rd(rv);
      chk(rv, 16'h0077);
      cpu_u.wr(8'ha5, 16'h0000);
      $display("register test done");
   endtask
   // raise every flag; a clear racing a set must lose
   task t_events;
      {i_oper_update, i_transfer_end_int, i_clk_wakeup} = 3'h7;
      cyc(1);
      {i_oper_update, i_transfer_end_int, i_clk_wakeup} = 3'h0;
      i_status_clear = 7'h04;
      i_transfer_end_ext = 1;
      cyc(1);
      i_status_clear = 7'h00;
      i_transfer_end_ext = 0;
      cyc(10);
      i_clk_stable = 1;
      cyc(1);
      i_clk_stable = 0;
      cyc(420);
      chk(o_clk_ready_late, 1'b0);
      i_clk_wakeup = 1;
      cyc(1);
      i_clk_wakeup = 0;
      cyc(60);
      chk(o_clk_ready_late, 1'b1);
      i_all_downstream_susp = 1;
      cpu_u.suspend();
      cyc(3);
      chk(o_sof_enable, 1'b0);
      chk(o_host_event_status, 7'h77);
      $display("event test done");
   endtask
   // one enable at a time, then pin gate off, then its flag cleared
   task t_gate;
      foreach (bits[k]) begin
         cpu_u.wr(8'ha5, 16'(16'h0001 << bits[k]));
         cyc(2);
         chk(o_host_irq_out, 1'b1);
         i_host_hw_config = 16'h0000;
         cyc(2);
         chk(o_host_irq_out, 1'b0);
         i_host_hw_config = 16'h0001;
         i_status_clear = 7'(7'h01 << bits[k]);
         cyc(1);
         i_status_clear = 7'h00;
         cyc(2);
         chk(o_host_irq_out, 1'b0);
      end
      $display("gate test done");
   endtask
   initial begin
      #50us;
      bad_count++;
      test_done;
   end
   initial begin
      i_reset = 1;
      {i_clk_wakeup, i_clk_stable, i_all_downstream_susp} = 3'h0;
      {i_oper_update, i_transfer_end_int, i_transfer_end_ext} = 3'h0;
      i_resume = 0;
      i_status_clear = 7'h00;
      i_host_hw_config = 16'h0001;
      i_async_budget_cyc = 16'h000a;
      cyc(3);
      i_reset = 0;
      t_regs;
      t_events;
      t_gate;
      test_done;
   end
endmodule
`default_nettype wire
